// *** hdl/cfgsl_loader.sv ***
// Configuration set loader: working set, startup load and file operations.
`timescale 1ns/100ps
module cfgsl_loader (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Manufacturing erase of the file store.
  input wire logic store_erase,
  // Command from the serial command decoder.
  input wire logic cmd_valid,
  input wire cfgsl_pkg::cfgsl_op_t cmd_op,
  input wire logic [cfgsl_pkg::FILE_W-1:0] cmd_file,
  // Command status.
  output logic busy,
  output logic done,
  output logic refused,
  output logic [cfgsl_pkg::FILE_W-1:0] linked_file,
  // Download stream to the host.
  output logic dl_valid,
  output logic [cfgsl_pkg::WORD_W-1:0] dl_data,
  // Upload stream from the host.
  input wire logic ul_valid,
  input wire logic [cfgsl_pkg::WORD_W-1:0] ul_data,
  output logic ul_ready,
  // Working set port used by the parameter registers.
  input wire logic ws_wr_en,
  input wire logic [cfgsl_pkg::IDX_W-1:0] ws_addr,
  input wire logic [cfgsl_pkg::WORD_W-1:0] ws_wdata,
  output logic [cfgsl_pkg::WORD_W-1:0] ws_rdata
);
  import cfgsl_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PICK,
    ST_BOOT,
    ST_IDLE,
    ST_SAVE,
    ST_LOAD,
    ST_DNLD,
    ST_UPLD
  } cfgsl_state_t;

  cfgsl_state_t state_ff, nxt_state;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic [FILE_W-1:0] file_ff, nxt_file;
  logic [WORD_W-1:0] ws_ff [WORDS];
  logic [WORD_W-1:0] nxt_ws [WORDS];
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic refused_ff, nxt_refused;
  logic [FILE_W-1:0] linked_ff, nxt_linked;
  logic dl_valid_ff, nxt_dl_valid;
  logic [WORD_W-1:0] dl_data_ff, nxt_dl_data;
  logic ul_ready_ff, nxt_ul_ready;
  logic [WORD_W-1:0] ws_rdata_ff, nxt_ws_rdata;
  logic user_ok;
  logic is_user;

  cfgsl_store_if st ();

  // ----------------------------------------------------------------
  // File store
  // ----------------------------------------------------------------
  cfgsl_store u_store (
    .core_clk(core_clk),
    .st(st.mem)
  );

  // A user file is usable only when its slot has been written.
  assign is_user = (cmd_file < FILE_FACTORY);
  assign user_ok = is_user && st.valid_q[cmd_file[1:0]];

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_file = file_ff;
    nxt_ws = ws_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_refused = 1'b0;
    nxt_linked = linked_ff;
    nxt_dl_valid = 1'b0;
    nxt_dl_data = dl_data_ff;
    nxt_ul_ready = 1'b0;
    nxt_ws_rdata = ws_ff[ws_addr];
    st.rd_file = file_ff;
    st.rd_idx = idx_ff;
    st.wr_en = 1'b0;
    st.wr_file = file_ff;
    st.wr_idx = idx_ff;
    st.wr_data = ws_ff[idx_ff];
    st.val_wr = 1'b0;
    st.val_set = 1'b0;
    st.link_wr = 1'b0;
    st.link_val = file_ff;
    st.erase = store_erase;
    case (state_ff)
      ST_PICK: begin
        // factory when none linked
        // A link to a user slot that is no longer valid falls back to factory.
        if (st.link_q < FILE_FACTORY && st.valid_q[st.link_q[1:0]]) begin
          nxt_file = st.link_q;
        end else begin
          nxt_file = FILE_FACTORY;
        end
        nxt_linked = nxt_file;
        nxt_idx = IDX_ZERO;
        nxt_state = ST_BOOT;
      end
      ST_BOOT, ST_LOAD: begin
        nxt_ws[idx_ff] = st.rd_data;
        nxt_idx = idx_ff + IDX_ONE;
        if (idx_ff == IDX_LAST) begin
          nxt_state = ST_IDLE;
          nxt_busy = 1'b0;
          if (state_ff == ST_LOAD) begin
            st.link_wr = 1'b1;
            nxt_linked = file_ff;
            nxt_done = 1'b1;
          end
        end
      end
      ST_IDLE: begin
        if (ws_wr_en) begin
          nxt_ws[ws_addr] = ws_wdata;
        end
        if (cmd_valid) begin
          nxt_file = cmd_file;
          nxt_idx = IDX_ZERO;
          case (cmd_op)
            OP_SAVE: begin
              if (is_user) begin
                nxt_state = ST_SAVE;
                nxt_busy = 1'b1;
              end else begin
                nxt_refused = 1'b1;
              end
            end
            OP_ACTIVATE: begin
              if (user_ok || cmd_file == FILE_FACTORY) begin
                nxt_state = ST_LOAD;
                nxt_busy = 1'b1;
              end else begin
                nxt_refused = 1'b1;
              end
            end
            OP_DOWNLOAD: begin
              if (user_ok) begin
                nxt_state = ST_DNLD;
                nxt_busy = 1'b1;
              end else begin
                nxt_refused = 1'b1;
              end
            end
            OP_UPLOAD: begin
              if (is_user) begin
                nxt_state = ST_UPLD;
                nxt_busy = 1'b1;
                nxt_ul_ready = 1'b1;
              end else begin
                nxt_refused = 1'b1;
              end
            end
            OP_DELETE: begin
              if (is_user) begin
                st.val_wr = 1'b1;
                st.wr_file = cmd_file;
                // Deleting the linked file hands startup back to factory.
                if (linked_ff == cmd_file) begin
                  st.link_wr = 1'b1;
                  st.link_val = FILE_FACTORY;
                  nxt_linked = FILE_FACTORY;
                end
                nxt_done = 1'b1;
              end else begin
                nxt_refused = 1'b1;
              end
            end
            default: begin
              nxt_refused = 1'b1;
            end
          endcase
        end
      end
      ST_SAVE: begin
        st.wr_en = 1'b1;
        nxt_idx = idx_ff + IDX_ONE;
        if (idx_ff == IDX_LAST) begin
          st.val_wr = 1'b1;
          st.val_set = 1'b1;
          nxt_state = ST_IDLE;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end
      end
      ST_DNLD: begin
        nxt_dl_valid = 1'b1;
        nxt_dl_data = st.rd_data;
        nxt_idx = idx_ff + IDX_ONE;
        if (idx_ff == IDX_LAST) begin
          nxt_state = ST_IDLE;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end
      end
      ST_UPLD: begin
        // host words into slot
        // The slot is marked invalid first so a broken upload never loads.
        st.val_wr = (idx_ff == IDX_ZERO) && ul_valid;
        st.val_set = 1'b0;
        nxt_ul_ready = 1'b1;
        if (ul_valid) begin
          st.wr_en = 1'b1;
          st.wr_data = ul_data;
          nxt_idx = idx_ff + IDX_ONE;
          if (idx_ff == IDX_LAST) begin
            st.val_wr = 1'b1;
            st.val_set = 1'b1;
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_ul_ready = 1'b0;
          end
        end
      end
      default: begin
        nxt_state = ST_PICK;
        nxt_busy = 1'b1;
      end
    endcase
    if (state_ff != ST_IDLE && cmd_valid) begin
      nxt_refused = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // working set cleared on reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= ST_PICK;
      idx_ff <= IDX_ZERO;
      file_ff <= FILE_FACTORY;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
      linked_ff <= FILE_FACTORY;
      dl_valid_ff <= 1'b0;
      dl_data_ff <= WORD_ZERO;
      ul_ready_ff <= 1'b0;
      ws_rdata_ff <= WORD_ZERO;
      for (int i = 0; i < WORDS; i++) begin
        ws_ff[i] <= WORD_ZERO;
      end
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      file_ff <= nxt_file;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      refused_ff <= nxt_refused;
      linked_ff <= nxt_linked;
      dl_valid_ff <= nxt_dl_valid;
      dl_data_ff <= nxt_dl_data;
      ul_ready_ff <= nxt_ul_ready;
      ws_rdata_ff <= nxt_ws_rdata;
      ws_ff <= nxt_ws;
    end
  end

  // Outputs straight from flip-flops.
  assign busy = busy_ff;
  assign done = done_ff;
  assign refused = refused_ff;
  assign linked_file = linked_ff;
  assign dl_valid = dl_valid_ff;
  assign dl_data = dl_data_ff;
  assign ul_ready = ul_ready_ff;
  assign ws_rdata = ws_rdata_ff;

endmodule // cfgsl_loader

// *** hdl/cfgsl_pkg.sv ***
// Constants and types shared by the configuration set store loader.
package cfgsl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int WORDS = 16;
  localparam int WORD_W = 16;
  localparam int IDX_W = 4;
  localparam int N_USER = 4;
  localparam int FILE_W = 3;

  // ----------------------------------------------------------------
  // File codes and constants
  // ----------------------------------------------------------------
  localparam logic [FILE_W-1:0] FILE_FACTORY = 3'h4;
  localparam logic [IDX_W-1:0] IDX_LAST = 4'hf;
  localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ONE = 4'h1;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  // Factory content is a fixed pattern; the values themselves are arbitrary.
  localparam logic [WORD_W-1:0] FACT_SEED = 16'h5a00;

  // ----------------------------------------------------------------
  // Command codes on the serial command link
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SAVE = 3'h0,
    OP_ACTIVATE = 3'h1,
    OP_DOWNLOAD = 3'h2,
    OP_UPLOAD = 3'h3,
    OP_DELETE = 3'h4
  } cfgsl_op_t;

  // Fixed factory word for a given index.
  function automatic logic [WORD_W-1:0] cfgsl_fact_word(input logic [IDX_W-1:0] idx);
    cfgsl_fact_word = FACT_SEED | {{(WORD_W-IDX_W){1'b0}}, idx};
  endfunction

endpackage

// *** hdl/cfgsl_store_if.sv ***
// Interface between the loader control and the non-volatile file store.
`timescale 1ns/100ps
interface cfgsl_store_if;
  import cfgsl_pkg::*;

  // Read side, combinational.
  logic [FILE_W-1:0] rd_file;
  logic [IDX_W-1:0] rd_idx;
  logic [WORD_W-1:0] rd_data;
  // Write side.
  logic wr_en;
  logic [FILE_W-1:0] wr_file;
  logic [IDX_W-1:0] wr_idx;
  logic [WORD_W-1:0] wr_data;
  // File valid flags and startup link.
  logic val_wr;
  logic val_set;
  logic link_wr;
  logic [FILE_W-1:0] link_val;
  logic [FILE_W-1:0] link_q;
  logic [N_USER-1:0] valid_q;
  logic erase;

  modport ctl (
    output rd_file, rd_idx, wr_en, wr_file, wr_idx, wr_data,
    output val_wr, val_set, link_wr, link_val, erase,
    input rd_data, link_q, valid_q
  );
  modport mem (
    input rd_file, rd_idx, wr_en, wr_file, wr_idx, wr_data,
    input val_wr, val_set, link_wr, link_val, erase,
    output rd_data, link_q, valid_q
  );
endinterface

// *** hdl/cfgsl_store.sv ***
// Non-volatile file store: four user files, the factory file and the startup link.
`timescale 1ns/100ps
module cfgsl_store (
  // Clock.
  input wire logic core_clk,
  // Control side.
  cfgsl_store_if.mem st
);
  import cfgsl_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // None of this takes the reset: it models retained storage, so only
  // the manufacturing erase puts the link and flags into a known state.
  logic [WORD_W-1:0] mem_ff [N_USER][WORDS];
  logic [N_USER-1:0] valid_ff;
  logic [FILE_W-1:0] link_ff;
  logic [N_USER-1:0] nxt_valid;
  logic [FILE_W-1:0] nxt_link;

  // factory never written
  // Factory reads come from a constant table; there is no write path to it.
  always_comb begin
    if (st.rd_file == FILE_FACTORY) begin
      st.rd_data = cfgsl_fact_word(st.rd_idx);
    end else begin
      st.rd_data = mem_ff[st.rd_file[1:0]][st.rd_idx];
    end
  end

  // Next values of the flags and the link.
  always_comb begin
    nxt_valid = valid_ff;
    nxt_link = link_ff;
    if (st.erase) begin
      nxt_valid = '0;
      nxt_link = FILE_FACTORY;
    end else begin
      if (st.val_wr && st.wr_file != FILE_FACTORY) begin
        nxt_valid[st.wr_file[1:0]] = st.val_set;
      end
      if (st.link_wr) begin
        nxt_link = st.link_val;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    valid_ff <= nxt_valid;
    link_ff <= nxt_link;
    if (st.wr_en && st.wr_file != FILE_FACTORY) begin
      mem_ff[st.wr_file[1:0]][st.wr_idx] <= st.wr_data;
    end
  end

  assign st.valid_q = valid_ff;
  assign st.link_q = link_ff;

endmodule // cfgsl_store

// *** dv/cfgsl_checker.sv ***
// Port assertions for the configuration set loader.
`timescale 1ns/100ps
module cfgsl_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Command and status.
  input wire logic cmd_valid,
  input wire cfgsl_pkg::cfgsl_op_t cmd_op,
  input wire logic [cfgsl_pkg::FILE_W-1:0] cmd_file,
  input wire logic busy,
  input wire logic done,
  input wire logic refused,
  input wire logic [cfgsl_pkg::FILE_W-1:0] linked_file,
  // Streams and working set.
  input wire logic dl_valid,
  input wire logic ul_ready,
  input wire logic ws_wr_en,
  input wire logic [cfgsl_pkg::IDX_W-1:0] ws_addr,
  input wire logic [cfgsl_pkg::WORD_W-1:0] ws_wdata,
  input wire logic [cfgsl_pkg::WORD_W-1:0] ws_rdata
);
  import cfgsl_pkg::*;
  logic take;

  // A command only counts while the loader is idle.
  assign take = cmd_valid && !busy;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_save;
    take && cmd_op == OP_SAVE && cmd_file < FILE_FACTORY |-> ##1 busy ##16 done;
  endproperty
  a_save: assert property (p_save) else $error("save did not end in 17 cycles");

  property p_factory;
    take && cmd_file >= FILE_FACTORY && cmd_op inside {OP_SAVE, OP_UPLOAD, OP_DELETE}
      |=> refused && !done;
  endproperty
  a_factory: assert property (p_factory) else $error("factory file change taken");

  property p_one_op;
    cmd_valid && busy |=> refused;
  endproperty
  a_one_op: assert property (p_one_op) else $error("command taken while busy");

  property p_activate;
    take && cmd_op == OP_ACTIVATE ##1 !refused
      |-> ##16 done && linked_file == $past(cmd_file, 17);
  endproperty
  a_activate: assert property (p_activate) else $error("activate link wrong");

  property p_download;
    take && cmd_op == OP_DOWNLOAD ##1 !refused
      |-> ##1 dl_valid [*8] ##1 dl_valid [*8] ##0 done;
  endproperty
  a_download: assert property (p_download) else $error("download burst wrong");

  property p_upload;
    $fell(ul_ready) |-> done && !busy;
  endproperty
  a_upload: assert property (p_upload) else $error("upload end without done");

  property p_startup;
    $fell(reset) |-> busy [*8] ##1 busy [*8] ##1 busy ##1 !busy;
  endproperty
  a_startup: assert property (p_startup) else $error("startup load length wrong");

  property p_work;
    ws_wr_en && !busy ##1 ws_addr == $past(ws_addr) |=> ws_rdata == $past(ws_wdata, 2);
  endproperty
  a_work: assert property (p_work) else $error("working word not kept");
endmodule // cfgsl_checker

bind cfgsl_loader cfgsl_checker u_chk (.core_clk, .reset, .cmd_valid, .cmd_op, .cmd_file,
  .busy, .done, .refused, .linked_file, .dl_valid, .ul_ready, .ws_wr_en, .ws_addr,
  .ws_wdata, .ws_rdata);

// *** dv/cfgsl_host_model.sv ***
// Host model that feeds upload words to the loader.
`timescale 1ns/100ps
module cfgsl_host_model (
  // Clock.
  input wire logic core_clk,
  // Upload handshake and pacing.
  input wire logic ul_ready,
  input wire logic slow,
  input wire logic [15:0] base,
  output logic ul_valid,
  output logic [15:0] ul_data
);
  logic [4:0] sent = 5'h00;
  logic [4:0] s;
  logic tog = 1'b0;

  initial ul_valid = 1'b0;
  initial ul_data = 16'h0000;

  // file words
  // Idle data is inverted so that a stale word can never pass for a fresh one.
  always @(posedge core_clk) begin
    tog <= ~tog;
    s = sent + {4'h0, ul_valid};
    if (ul_ready && s < 5'h10 && (!slow || tog)) begin
      ul_valid <= 1'b1;
      ul_data <= base + {11'h000, s};
    end else begin
      ul_valid <= 1'b0;
      ul_data <= ~ul_data;
    end
    sent <= ul_ready ? s : 5'h00;
  end
endmodule // cfgsl_host_model

// *** dv/tb.sv ***
// Self-checking testbench for the configuration set loader.
`timescale 1ns/100ps
module tb;
  import cfgsl_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic store_erase = 1'b1;
  logic cmd_valid = 1'b0;
  cfgsl_op_t cmd_op = OP_SAVE;
  logic [FILE_W-1:0] cmd_file = 3'h0;
  logic ws_wr_en = 1'b0;
  logic [IDX_W-1:0] ws_addr = 4'h0;
  logic [WORD_W-1:0] ws_wdata = 16'h0000;
  logic slow = 1'b0;
  logic busy, done, refused, dl_valid, ul_valid, ul_ready;
  logic [FILE_W-1:0] linked_file;
  logic [WORD_W-1:0] dl_data, ul_data, ws_rdata;
  logic [WORD_W-1:0] got [16];
  int n_dl;
  int bad_count = 0;
  int check_count = 0;

  // Core clock.
  always #50 core_clk = ~core_clk;

  cfgsl_loader dut (.core_clk, .reset, .store_erase, .cmd_valid, .cmd_op, .cmd_file,
    .busy, .done, .refused, .linked_file, .dl_valid, .dl_data, .ul_valid, .ul_data,
    .ul_ready, .ws_wr_en, .ws_addr, .ws_wdata, .ws_rdata);
  cfgsl_host_model host (.core_clk, .ul_ready, .slow, .base(16'h3000), .ul_valid, .ul_data);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    chk(what, {15'h0, e}, {15'h0, g});
  endtask

  task automatic hang();
    chk_bit("completion", 1'b1, 1'b0);
    stop_test();
  endtask

  // Waits for busy to drop; the loop bound stops a hang.
  task automatic wait_idle();
    int k;
    k = 60;
    do begin
      @(posedge core_clk);
      #1;
      k--;
    end while (busy !== 1'b0 && k > 0);
    if (busy !== 1'b0) hang();
  endtask

  task automatic send(input cfgsl_op_t op, input logic [2:0] f);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_file <= f;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask

  // Issues one command, gathers any download words, checks the refusal flag.
  task automatic run(input cfgsl_op_t op, input logic [2:0] f, input logic er);
    int k;
    k = 80;
    n_dl = 0;
    send(op, f);
    // A refusal or a delete answers at the take edge and stands one cycle, so look at once.
    #1;
    while (done !== 1'b1 && refused !== 1'b1 && k > 0) begin
      @(posedge core_clk);
      #1;
      if (dl_valid === 1'b1 && n_dl < 16) begin
        got[n_dl] = dl_data;
        n_dl++;
      end
      k--;
    end
    if (done !== 1'b1 && refused !== 1'b1) hang();
    chk_bit("refused", er, refused);
  endtask

  task automatic ws_fill(input logic [15:0] b);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      ws_wr_en <= 1'b1;
      ws_addr <= i[3:0];
      ws_wdata <= b + 16'(i);
    end
    @(posedge core_clk);
    ws_wr_en <= 1'b0;
  endtask

  task automatic ws_check(input logic [15:0] b);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      ws_addr <= i[3:0];
      @(posedge core_clk);
      #1;
      chk("working word", b + 16'(i), ws_rdata);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    store_erase <= 1'b0;
    wait_idle();
  endtask

  task automatic t_save_act();
    ws_fill(16'h1000);
    run(OP_SAVE, 3'h3, 1'b0);
    ws_fill(16'h7700);
    run(OP_ACTIVATE, 3'h0, 1'b1);
    run(OP_ACTIVATE, 3'h5, 1'b1);
    run(OP_ACTIVATE, 3'h3, 1'b0);
    ws_check(16'h1000);
    chk("linked file", 16'h0003, 16'(linked_file));
    ws_fill(16'h7700);
    do_reset();
    ws_check(16'h1000);
    $display("save and activate test done");
  endtask

  task automatic t_dl_busy();
    run(OP_DOWNLOAD, 3'h1, 1'b1);
    run(OP_DOWNLOAD, 3'h3, 1'b0);
    chk("download count", 16'h0010, 16'(n_dl));
    for (int i = 0; i < 16; i++) chk("download word", 16'h1000 + 16'(i), got[i]);
    send(OP_SAVE, 3'h1);
    send(OP_DELETE, 3'h0);
    // The refusal pulse rises at the edge that send returns on.
    #1;
    chk_bit("refused while busy", 1'b1, refused);
    wait_idle();
    $display("download and busy test done");
  endtask

  task automatic t_ul_factory();
    slow <= 1'b1;
    run(OP_UPLOAD, 3'h2, 1'b0);
    run(OP_ACTIVATE, 3'h2, 1'b0);
    ws_check(16'h3000);
    // Deleting the linked slot must hand startup back to the factory file.
    run(OP_DELETE, 3'h2, 1'b0);
    chk("linked file", 16'h0004, 16'(linked_file));
    run(OP_ACTIVATE, 3'h2, 1'b1);
    run(OP_SAVE, 3'h4, 1'b1);
    run(OP_UPLOAD, 3'h4, 1'b1);
    run(OP_DELETE, 3'h4, 1'b1);
    run(OP_ACTIVATE, 3'h4, 1'b0);
    chk("linked file", 16'h0004, 16'(linked_file));
    do_reset();
    ws_check(16'h5a00);
    $display("upload and factory test done");
  endtask

  // Main sequence: erase the store under reset, then each test in turn.
  initial begin
    do_reset();
    chk("linked file", 16'h0004, 16'(linked_file));
    ws_check(16'h5a00);
    $display("startup test done");
    t_save_act();
    t_dl_busy();
    t_ul_factory();
    stop_test();
  end
endmodule // tb
